// ---- tb/nvcsac_buf_model.sv ----
// buffer register bank seen across the config store
`timescale 1ns/100ps
`default_nettype none
module nvcsac_buf_model (
  input  wire logic        ref_clk,
  input  wire logic [11:0] buf_addr,
  input  wire logic [7:0]  buf_wdata,
  input  wire logic        buf_we,
  output logic      [7:0]  buf_rdata
);
  logic [7:0] mem [0:4095];

  // combinational read, clocked write
  assign buf_rdata = mem[buf_addr];
  always @(posedge ref_clk)
  begin
    if (buf_we)
      mem[buf_addr] <= buf_wdata;
  end
endmodule : nvcsac_buf_model
`default_nettype wire

// ---- tb/nvcsac_config_store_bench.sv ----
// register level tests of the config store
`timescale 1ns/100ps
`default_nettype none
module nvcsac_config_store_bench;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        sclk = 1'b0;
  logic        boot_sel = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  wire  [7:0]  reg_rdata;
  wire  [11:0] buf_addr;
  wire  [7:0]  buf_wdata;
  wire  [7:0]  buf_rdata;
  wire         buf_we;
  wire         active_load;
  wire         soft_reset;
  wire         status_pin_zero;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          n_load = 0;
  int          n_rst = 0;
  int          i;

  nvcsac_config_store DUT (.ref_clk(ref_clk), .resetn(resetn), .sclk(sclk), .boot_sel(boot_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_we(buf_we), .buf_rdata(buf_rdata),
    .active_load(active_load), .soft_reset(soft_reset), .status_pin_zero(status_pin_zero));
  nvcsac_buf_model u_buf (.ref_clk(ref_clk), .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_we(buf_we),
    .buf_rdata(buf_rdata));

  // clock, load pulse and reload pulse counters
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (active_load === 1'b1) n_load++;
  always @(posedge ref_clk) if (soft_reset === 1'b1) n_rst++;

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    check(what, reg_rdata, exp);
  endtask : rd

  // let the request edge pass so the pin can rise, then wait for it to drop, bounded
  task wait_idle;
    @(posedge ref_clk);
    for (int k = 0; k < 3000 && status_pin_zero !== 1'b0; k++) @(posedge ref_clk);
    check("transfer done", {7'h00, status_pin_zero}, 8'h00);
  endtask : wait_idle

  // wipe buffer bytes, reload, compare the first n restored
  task reload(input int n, input logic [7:0] err);
    for (int k = 0; k < 4; k++) u_buf.mem[12'h0120 + k] = 8'h00;
    n_load = 0;
    n_rst = 0;
    wr(12'h0b02, 8'h03);
    wait_idle;
    for (int k = 0; k < 4; k++) check("restored", u_buf.mem[12'h0120 + k], k < n ? 8'ha1 + 8'(k * 17) : 8'h00);
    check("reload commit", 8'(n_load), 8'h01);
    check("reload pulse", 8'(n_rst), 8'h01);
    rd(12'h0b01, err, "data error");
    rd(12'h0b02, 8'h01, "reload bit");
  endtask : reload

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  initial
  begin
    #(20 * 40000);
    n_mismatch++;
    close_out;
  end

  initial
  begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(12'h0b02, 8'h00, "write enable");
    rd(12'h0b00, 8'h00, "idle state");
    rd(12'h0a00, 8'h1f, "list count");
    rd(12'h0a06, 8'h34, "list last count");
    rd(12'h0a09, 8'h80, "list commit");
    rd(12'h0a0a, 8'hff, "list end");
    rd(12'h0300, 8'h00, "unmapped");
    $display("test reset values done");
    n_load = 0;
    wr(12'h0234, 8'h01);
    repeat (5) @(posedge ref_clk);
    check("load before sclk", 8'(n_load), 8'h00);
    sclk <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sclk <= 1'b0;
    check("load on sclk", 8'(n_load), 8'h01);
    rd(12'h0234, 8'h00, "commit bit");
    sclk <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sclk <= 1'b0;
    check("no second load", 8'(n_load), 8'h01);
    $display("test commit done");
    wr(12'h0a00, 8'h03);
    wr(12'h0a01, 8'h01);
    wr(12'h0a02, 8'h20);
    wr(12'h0a03, 8'h80);
    wr(12'h0a04, 8'hff);
    for (i = 0; i < 4; i++) u_buf.mem[12'h0120 + i] = 8'ha1 + 8'(i * 17);
    wr(12'h0b03, 8'h01);
    rd(12'h0b00, 8'h00, "protected store");
    wr(12'h0232, 8'h10);
    wr(12'h0b02, 8'h01);
    n_load = 0;
    wr(12'h0b03, 8'h01);
    rd(12'h0b00, 8'h01, "store busy");
    check("status pin", {7'h00, status_pin_zero}, 8'h01);
    wait_idle;
    rd(12'h0b03, 8'h00, "store bit");
    check("store commit", 8'(n_load), 8'h00);
    $display("test store done");
    n_rst = 0;
    wr(12'h0b02, 8'h03);
    rd(12'h0b00, 8'h00, "refused reload");
    check("no reload pulse", 8'(n_rst), 8'h00);
    boot_sel <= 1'b0;
    reload(4, 8'h00);
    wr(12'h0a00, 8'h02);
    reload(3, 8'h01);
    $display("test reload done");
    wr(12'h0a00, 8'h03);
    wr(12'h0b02, 8'h00);
    for (i = 0; i < 4; i++) u_buf.mem[12'h0120 + i] = 8'h55;
    wr(12'h0b03, 8'h01);
    rd(12'h0b00, 8'h00, "store dropped");
    reload(4, 8'h00);
    $display("test protection done");
    close_out;
  end
endmodule : nvcsac_config_store_bench
`default_nettype wire

// ---- tb/nvcsac_config_store_chk.sv ----
// port assertions for the config store
`timescale 1ns/100ps
`default_nettype none
module nvcsac_config_store_chk (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        sclk,
  input wire logic        boot_sel,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [11:0] buf_addr,
  input wire logic [7:0]  buf_wdata,
  input wire logic        buf_we,
  input wire logic [7:0]  buf_rdata,
  input wire logic        active_load,
  input wire logic        soft_reset,
  input wire logic        status_pin_zero
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // read port and register map
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_wo_reads_zero: assert property (reg_rd && (reg_addr == 12'h0234 || reg_addr == 12'h0b03) |=> reg_rdata == 8'h00)
    else $error("self clearing bit read back set");
  a_xfer_upper_zero: assert property (reg_rd && reg_addr == 12'h0b00 |=> reg_rdata[7:1] == 7'h00)
    else $error("transfer state upper bits set");
  a_error_upper_zero: assert property (reg_rd && reg_addr == 12'h0b01 |=> reg_rdata[7:1] == 7'h00)
    else $error("error register upper bits set");
  a_reload_bit_clear: assert property (reg_rd && reg_addr == 12'h0b02 |=> reg_rdata[7:1] == 7'h00)
    else $error("reload bit did not clear");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 12'h0300 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // reload and transfer pulses
  a_reload_refused: assert property (reg_wr && reg_addr == 12'h0b02 && reg_wdata[1] && boot_sel |=> !soft_reset)
    else $error("reload acted with boot select high");
  a_reset_once: assert property (soft_reset |=> !soft_reset [*8])
    else $error("soft reset repeated");
  a_load_once: assert property (active_load |=> !active_load)
    else $error("active load longer than one cycle");
  a_we_once: assert property (buf_we |=> !buf_we)
    else $error("buffer write longer than one cycle");
  a_pin_means_busy: assert property (reg_rd && reg_addr == 12'h0b00 && status_pin_zero |=> reg_rdata[0])
    else $error("status pin high while transfer idle");
endmodule : nvcsac_config_store_chk
bind nvcsac_config_store nvcsac_config_store_chk u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .sclk(sclk), .boot_sel(boot_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .buf_addr(buf_addr),
  .buf_wdata(buf_wdata), .buf_we(buf_we), .buf_rdata(buf_rdata), .active_load(active_load),
  .soft_reset(soft_reset), .status_pin_zero(status_pin_zero));
`default_nettype wire

// ---- verilog/nvcsac_config_store.sv ----
// config store and commit: register port, segment walker, transfer status
`timescale 1ns/100ps
`include "nvcsac_defines.svh"
`default_nettype none

// Functional notes
// - commit copies buffer to active on sclk rise
// - commit bit clears itself after the copy
// - segment list gives start address and count
// - list opcodes: commit copies on reload only, end stops walk
// - default list covers three ranges, then commits
// - transfer status reads one while busy
// - status config bit 4 routes status to pin
// - error bit flags bad checksum on reload
// - soft reload with boot pin low, self clears
// - write enable resets zero, blocks stores
// - store bit starts buffer to nonvolatile copy
// - store bit returns zero when finished
module nvcsac_config_store (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        boot_sel,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic      [11:0] buf_addr,
  output logic      [7:0]  buf_wdata,
  output logic             buf_we,
  input  wire logic [7:0]  buf_rdata,
  output logic             active_load,
  output logic             soft_reset,
  output logic             status_pin_zero
);

  nvcsac_pkg::nvcsac_main_type r_ff;
  nvcsac_pkg::nvcsac_main_type nxt_r;

  logic [7:0] seg_rd_data;
  logic [7:0] seg_fetch;
  logic [7:0] nv_rdata;
  logic       nv_busy;
  logic       seg_wr;
  logic       busy;

  // host writes into the segment list range
  assign seg_wr = reg_wr && (reg_addr >= `NVCSAC_ADDR_SEG_FIRST) && (reg_addr <= `NVCSAC_ADDR_SEG_LAST);
  assign busy   = (r_ff.state != nvcsac_pkg::NVCSAC_IDLE);

  nvcsac_seg_list u_seg (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .wr_i         (seg_wr),
    .wr_idx_i     (reg_addr[4:0]),
    .wr_data_i    (reg_wdata),
    .rd_idx_i     (reg_addr[4:0]),
    .rd_data_o    (seg_rd_data),
    .fetch_idx_i  (r_ff.seg_idx),
    .fetch_data_o (seg_fetch)
  );

  nvcsac_nv_array u_nv (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .addr_i  (r_ff.nv_addr),
    .we_i    (r_ff.nv_we),
    .wdata_i (r_ff.nv_wdata),
    .rdata_o (nv_rdata),
    .busy_o  (nv_busy)
  );

  // register port, commit timing and segment walker
  always_comb
  begin
    nxt_r             = r_ff;
    nxt_r.sclk_q      = sclk;
    nxt_r.active_load = 1'b0;
    nxt_r.soft_reset  = 1'b0;
    nxt_r.nv_we       = 1'b0;
    nxt_r.buf_we      = 1'b0;

    // pending commit fires on the next serial clock rise, then drops
    if (r_ff.pend_commit && sclk && !r_ff.sclk_q)
    begin
      nxt_r.active_load = 1'b1;
      nxt_r.pend_commit = 1'b0;
    end

    // register reads; reserved bits read zero
    if (reg_rd)
    begin
      case (reg_addr)
        `NVCSAC_ADDR_STATUS_CFG:  nxt_r.rdata = 8'({r_ff.st_pin_en, 4'h0});
        `NVCSAC_ADDR_XFER_STATE:  nxt_r.rdata = {7'h00, busy};
        `NVCSAC_ADDR_ERROR:       nxt_r.rdata = {7'h00, r_ff.error};
        `NVCSAC_ADDR_CTRL_FIRST:  nxt_r.rdata = {7'h00, r_ff.wr_enable};
        default:
        begin
          if ((reg_addr >= `NVCSAC_ADDR_SEG_FIRST) && (reg_addr <= `NVCSAC_ADDR_SEG_LAST))
          begin
            nxt_r.rdata = seg_rd_data;
          end
          else
          begin
            nxt_r.rdata = 8'h00;
          end
        end
      endcase
    end

    // register writes; the request bits read back zero, the commit bit is held pending
    if (reg_wr)
    begin
      case (reg_addr)
        `NVCSAC_ADDR_STATUS_CFG:
        begin
          nxt_r.st_pin_en = reg_wdata[`NVCSAC_BIT_STATUS_PIN_EN];
        end
        `NVCSAC_ADDR_COMMIT:
        begin
          if (reg_wdata[`NVCSAC_BIT_COMMIT])
          begin
            nxt_r.pend_commit = 1'b1;
          end
        end
        `NVCSAC_ADDR_CTRL_FIRST:
        begin
          nxt_r.wr_enable = reg_wdata[`NVCSAC_BIT_WR_ENABLE];
          if (reg_wdata[`NVCSAC_BIT_SOFT_RELOAD] && !boot_sel && !busy)
          begin
            nxt_r.soft_reset = 1'b1;
            nxt_r.state      = nvcsac_pkg::NVCSAC_OP;
            nxt_r.store      = 1'b0;
            nxt_r.seg_idx    = 5'h00;
            nxt_r.nv_addr    = 10'h000;
            nxt_r.sum        = 8'h00;
          end
        end
        `NVCSAC_ADDR_CTRL_SECOND:
        begin
          // protected store is dropped, nonvolatile array untouched
          if (reg_wdata[`NVCSAC_BIT_STORE] && r_ff.wr_enable && !busy)
          begin
            nxt_r.state   = nvcsac_pkg::NVCSAC_OP;
            nxt_r.store   = 1'b1;
            nxt_r.seg_idx = 5'h00;
            nxt_r.nv_addr = 10'h000;
            nxt_r.sum     = 8'h00;
          end
        end
        default:
        begin
        end
      endcase
    end

    // walk the segment list
    case (r_ff.state)
      nvcsac_pkg::NVCSAC_IDLE:
      begin
      end
      nvcsac_pkg::NVCSAC_OP:
      begin
        nxt_r.seg_idx = r_ff.seg_idx + 5'h01;
        if (nvcsac_pkg::nvcsac_is_data(seg_fetch))
        begin
          nxt_r.cnt   = seg_fetch[6:0];
          nxt_r.state = nvcsac_pkg::NVCSAC_AHI;
        end
        else if (seg_fetch == `NVCSAC_OP_COMMIT)
        begin
          nxt_r.active_load = !r_ff.store;
        end
        else
        begin
          nxt_r.state = nvcsac_pkg::NVCSAC_CADDR;
        end
      end
      nvcsac_pkg::NVCSAC_AHI:
      begin
        nxt_r.addr[11:8] = seg_fetch[3:0];
        nxt_r.seg_idx    = r_ff.seg_idx + 5'h01;
        nxt_r.state      = nvcsac_pkg::NVCSAC_ALO;
      end
      nvcsac_pkg::NVCSAC_ALO:
      begin
        nxt_r.addr[7:0] = seg_fetch;
        nxt_r.seg_idx   = r_ff.seg_idx + 5'h01;
        nxt_r.state     = nvcsac_pkg::NVCSAC_XADDR;
      end
      nvcsac_pkg::NVCSAC_XADDR:
      begin
        nxt_r.buf_addr = r_ff.addr;
        nxt_r.state    = nvcsac_pkg::NVCSAC_XWAIT;
      end
      nvcsac_pkg::NVCSAC_XWAIT:
      begin
        nxt_r.state = nvcsac_pkg::NVCSAC_XDATA;
      end
      nvcsac_pkg::NVCSAC_XDATA:
      begin
        if (r_ff.store)
        begin
          nxt_r.nv_we    = 1'b1;
          nxt_r.nv_wdata = buf_rdata;
          nxt_r.sum      = r_ff.sum + buf_rdata;
          nxt_r.state    = nvcsac_pkg::NVCSAC_WWAIT;
        end
        else
        begin
          nxt_r.buf_we    = 1'b1;
          nxt_r.buf_wdata = nv_rdata;
          nxt_r.sum       = r_ff.sum + nv_rdata;
          nxt_r.nv_addr   = r_ff.nv_addr + 10'h001;
          nxt_r.addr      = r_ff.addr + 12'h001;
          nxt_r.cnt       = r_ff.cnt - 7'h01;
          nxt_r.state     = (r_ff.cnt == 7'h00) ? nvcsac_pkg::NVCSAC_OP : nvcsac_pkg::NVCSAC_XADDR;
        end
      end
      nvcsac_pkg::NVCSAC_WWAIT:
      begin
        if (!nv_busy)
        begin
          nxt_r.nv_addr = r_ff.nv_addr + 10'h001;
          nxt_r.addr    = r_ff.addr + 12'h001;
          nxt_r.cnt     = r_ff.cnt - 7'h01;
          nxt_r.state   = (r_ff.cnt == 7'h00) ? nvcsac_pkg::NVCSAC_OP : nvcsac_pkg::NVCSAC_XADDR;
        end
      end
      nvcsac_pkg::NVCSAC_CADDR:
      begin
        if (r_ff.store)
        begin
          nxt_r.nv_we    = 1'b1;
          nxt_r.nv_wdata = r_ff.sum;
          nxt_r.state    = nvcsac_pkg::NVCSAC_CWWAIT;
        end
        else
        begin
          nxt_r.state = nvcsac_pkg::NVCSAC_CWAIT;
        end
      end
      nvcsac_pkg::NVCSAC_CWAIT:
      begin
        nxt_r.state = nvcsac_pkg::NVCSAC_CDATA;
      end
      nvcsac_pkg::NVCSAC_CDATA:
      begin
        nxt_r.error = (nv_rdata != r_ff.sum);
        nxt_r.state = nvcsac_pkg::NVCSAC_IDLE;
      end
      nvcsac_pkg::NVCSAC_CWWAIT:
      begin
        if (!nv_busy)
        begin
          nxt_r.state = nvcsac_pkg::NVCSAC_IDLE;
        end
      end
      default:
      begin
        nxt_r.state = nvcsac_pkg::NVCSAC_IDLE;
      end
    endcase

    // status pin shows the next-cycle transfer state when routed
    nxt_r.status_pin = nxt_r.st_pin_en && (nxt_r.state != nvcsac_pkg::NVCSAC_IDLE);
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      r_ff           <= '0;
      r_ff.state     <= nvcsac_pkg::NVCSAC_IDLE;
      r_ff.wr_enable <= `NVCSAC_WR_ENABLE_RESET;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign reg_rdata       = r_ff.rdata;
  assign buf_addr        = r_ff.buf_addr;
  assign buf_wdata       = r_ff.buf_wdata;
  assign buf_we          = r_ff.buf_we;
  assign active_load     = r_ff.active_load;
  assign soft_reset      = r_ff.soft_reset;
  assign status_pin_zero = r_ff.status_pin;

endmodule : nvcsac_config_store
`default_nettype wire

// ---- verilog/nvcsac_defines.svh ----
// register offsets, bit positions, reset values and timing counts of the config store
`ifndef NVCSAC_DEFINES_SVH
`define NVCSAC_DEFINES_SVH

`define NVCSAC_ADDR_STATUS_CFG   12'h0232
`define NVCSAC_ADDR_COMMIT       12'h0234
`define NVCSAC_ADDR_SEG_FIRST    12'h0a00
`define NVCSAC_ADDR_SEG_LAST     12'h0a16
`define NVCSAC_ADDR_XFER_STATE   12'h0b00
`define NVCSAC_ADDR_ERROR        12'h0b01
`define NVCSAC_ADDR_CTRL_FIRST   12'h0b02
`define NVCSAC_ADDR_CTRL_SECOND  12'h0b03

`define NVCSAC_BIT_STATUS_PIN_EN 4
`define NVCSAC_BIT_COMMIT        0
`define NVCSAC_BIT_BUSY          0
`define NVCSAC_BIT_ERROR         0
`define NVCSAC_BIT_WR_ENABLE     0
`define NVCSAC_BIT_SOFT_RELOAD   1
`define NVCSAC_BIT_STORE         0

`define NVCSAC_SEG_COUNT         23
`define NVCSAC_OP_COMMIT         8'h80
`define NVCSAC_OP_END            8'hff
`define NVCSAC_WR_ENABLE_RESET   1'b0

// default list: 32 bytes at 0x000, 64 at 0x100, 53 at 0x200, commit, end; entry byte 0 sits lowest
`define NVCSAC_SEG_DEFAULT {{12{8'hff}}, 8'hff, 8'h80, 8'h00, 8'h02, 8'h34, 8'h00, 8'h01, 8'h3f, 8'h00, 8'h00, 8'h1f}

`define NVCSAC_CLK_PERIOD_NS     20
`define NVCSAC_NV_WR_TIME_NS     200
`define NVCSAC_NV_WR_CYCLES      ((`NVCSAC_NV_WR_TIME_NS + `NVCSAC_CLK_PERIOD_NS - 1) / `NVCSAC_CLK_PERIOD_NS)

`endif

// ---- verilog/nvcsac_nv_array.sv ----
// on-package nonvolatile byte array with a timed write cycle
`timescale 1ns/100ps
`include "nvcsac_defines.svh"
`default_nettype none
module nvcsac_nv_array (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [9:0]  addr_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  output logic             busy_o
);

  logic [7:0] mem [0:1023];
  nvcsac_pkg::nvcsac_nv_type r_ff;
  nvcsac_pkg::nvcsac_nv_type nxt_r;

  // read is registered; a write holds busy for the programming time
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.rd_data = mem[addr_i];
    if (we_i)
    begin
      nxt_r.wait_cnt = 4'(`NVCSAC_NV_WR_CYCLES);
    end
    else if (r_ff.wait_cnt != 4'h0)
    begin
      nxt_r.wait_cnt = r_ff.wait_cnt - 4'h1;
    end
  end

  // contents survive reset, the timer and the read data register clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      r_ff <= '0;
    end
    else
    begin
      r_ff <= nxt_r;
    end
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = r_ff.rd_data;
  assign busy_o  = we_i | (r_ff.wait_cnt != 4'h0);

endmodule : nvcsac_nv_array
`default_nettype wire

// ---- verilog/nvcsac_pkg.sv ----
// types and entry decoding shared by the config store files
`default_nettype none
package nvcsac_pkg;

  typedef enum logic [3:0] {
    NVCSAC_IDLE, NVCSAC_OP, NVCSAC_AHI, NVCSAC_ALO,
    NVCSAC_XADDR, NVCSAC_XWAIT, NVCSAC_XDATA, NVCSAC_WWAIT,
    NVCSAC_CADDR, NVCSAC_CWAIT, NVCSAC_CDATA, NVCSAC_CWWAIT
  } nvcsac_state_type;

  typedef struct packed {
    nvcsac_state_type state;
    logic             store;
    logic             pend_commit;
    logic             sclk_q;
    logic             wr_enable;
    logic             st_pin_en;
    logic             error;
    logic [4:0]       seg_idx;
    logic [6:0]       cnt;
    logic [11:0]      addr;
    logic [7:0]       sum;
    logic [9:0]       nv_addr;
    logic             nv_we;
    logic [7:0]       nv_wdata;
    logic             active_load;
    logic             status_pin;
    logic [7:0]       rdata;
    logic [11:0]      buf_addr;
    logic [7:0]       buf_wdata;
    logic             buf_we;
    logic             soft_reset;
  } nvcsac_main_type;

  typedef struct packed {
    logic [183:0] seg;
  } nvcsac_seg_type;

  typedef struct packed {
    logic [3:0] wait_cnt;
    logic [7:0] rd_data;
  } nvcsac_nv_type;

  // data entry: bit 7 clear, low bits hold byte count minus one
  function automatic logic nvcsac_is_data(input logic [7:0] b);
    nvcsac_is_data = ~b[7];
  endfunction : nvcsac_is_data

endpackage : nvcsac_pkg
`default_nettype wire

// ---- verilog/nvcsac_seg_list.sv ----
// segment list storage with power-on default contents
`timescale 1ns/100ps
`include "nvcsac_defines.svh"
`default_nettype none
module nvcsac_seg_list (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        wr_i,
  input  wire logic [4:0]  wr_idx_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic [4:0]  rd_idx_i,
  output logic      [7:0]  rd_data_o,
  input  wire logic [4:0]  fetch_idx_i,
  output logic      [7:0]  fetch_data_o
);

  nvcsac_pkg::nvcsac_seg_type r_ff;
  nvcsac_pkg::nvcsac_seg_type nxt_r;

  // host writes one byte of the list
  always_comb
  begin
    nxt_r = r_ff;
    if (wr_i && (wr_idx_i < 5'(`NVCSAC_SEG_COUNT)))
    begin
      nxt_r.seg[wr_idx_i*8 +: 8] = wr_data_i;
    end
  end

  // default list covers the 0x000, 0x100 and 0x200 ranges then commits
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      r_ff.seg <= `NVCSAC_SEG_DEFAULT;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // reads past the last entry see the end opcode
  assign rd_data_o    = (rd_idx_i < 5'(`NVCSAC_SEG_COUNT)) ? r_ff.seg[rd_idx_i*8 +: 8] : `NVCSAC_OP_END;
  assign fetch_data_o = (fetch_idx_i < 5'(`NVCSAC_SEG_COUNT)) ? r_ff.seg[fetch_idx_i*8 +: 8] : `NVCSAC_OP_END;

endmodule : nvcsac_seg_list
`default_nettype wire
